/* File: logic/phy_vendor_regs.sv */
`timescale 1ns/1ps
// Contract
// - Status bit 13 low allows automatic reduced power; high suppresses; resets high.
// - Bit 11 shows 100 Mb/s deserializer lock; bit 8 shows receive polarity.
// - Bits 10 and 9 show 100 and 10 Mb/s power-down; reset high.
// - Bits 6 to 2 show the strap-latched management address.
// - Bit 1 shows negotiated speed; bit 0 shows negotiated duplex.
// - Special bit 15 bypasses scrambler; bit 14 bypasses 4B5B encoding.
// - Special bits 13 and 12 force H and 34 transmit patterns.
// - Special bit 11 forces the 100 Mb/s link valid.
// - Special bit 10 enables the receive symbol error output.
// - Special bit 9 suppresses 100 Mb/s receive carrier sense.
// - Special bit 8 prevents dynamic power-down.
// - Special bit 7 puts negotiation into loopback.
// - Special bit 6 tri-states the line transmit drivers.
// - Special bit 5 forces reversed polarity; bit 4 disables auto polarity.
// - Special bit 3 disables squelch test; bit 2 enables extended squelch.
// - Special bit 1 disables link integrity; bit 0 disables jabber.
// - Address register returns the address in bits 4 to 0, resets 00001.
// - False carrier events counted in 16 bits, cleared when read.
// - Disconnect events counted, saturating, cleared when read.
// - Error frames counted once per frame, saturating, cleared when read.
// - Each run of six bad symbols in a frame counts one, saturating.
module phy_vendor_regs
    import phy_vsc_pkg::*;
#(
    parameter int CNT_WIDTH = 16
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Strap and line status
    input  wire logic [4:0]  addr_strap,
    input  wire logic        rx_sync,
    input  wire logic        pd100_state,
    input  wire logic        pd10_state,
    input  wire logic        rx_polarity_rev,
    input  wire logic        link_speed100,
    input  wire logic        link_full_duplex,
    // Receive events
    input  wire logic        false_carrier_evt,
    input  wire logic        disconnect_evt,
    input  wire logic        rx_frame_active,
    input  wire logic        rx_frame_err,
    input  wire logic        rx_bad_symbol,
    input  wire logic        rx_symbol_err_raw,
    // Controls to the datapath
    output logic             auto_rpd_enable,
    output logic             scrambler_bypass,
    output logic             enc_bypass,
    output logic             tx_h_pattern,
    output logic             tx_34_pattern,
    output logic             force_link_valid,
    output logic             rx_symbol_err_out,
    output logic             rx_crs_disable,
    output logic             dyn_pd_allow,
    output logic             neg_loopback,
    output logic             tx_drive_oe_n,
    output logic             force_polarity_rev,
    output logic             autopol_disable,
    output logic             squelch_test_disable,
    output logic             ext_squelch_enable,
    output logic             link_integrity_disable,
    output logic             jabber_disable
);
    // Refused at elaboration: each counter fills one 16-bit register
    if (CNT_WIDTH != 16) begin : g_bad_width
        $error("CNT_WIDTH must be 16 to fill the register");
    end

    // ==========================================================
    // Bus decode
    logic        ack_r;
    logic        req;
    logic [7:0]  idx;
    logic        wr_lo;
    logic        rd_take;

    assign req     = wb_cyc_i && wb_stb_i && !ack_r;
    assign idx     = wb_adr_i[9:2];
    assign wr_lo   = req && wb_we_i && wb_sel_i[0] && wb_sel_i[1];
    assign rd_take = req && !wb_we_i;
    assign wb_ack_o = ack_r;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req;
        end
    end

    // ==========================================================
    // Control registers
    logic        rpd_disable_r;
    logic [15:0] special_r;
    logic [4:0]  addr_latch_r;
    logic        strap_taken_r;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rpd_disable_r <= SC_RPD_DISABLE_RST;
        end else if (wr_lo && idx == IDX_STATUS_CONTROL) begin
            rpd_disable_r <= wb_dat_i[SC_RPD_DISABLE_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            special_r <= SP_RESET;
        end else if (wr_lo && idx == IDX_SPECIAL_CONTROL) begin
            special_r <= wb_dat_i[15:0];
        end
    end

    // Straps are caught on the first clock after reset release
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            addr_latch_r  <= ADDR_READ_RESET;
            strap_taken_r <= 1'b0;
        end else if (!strap_taken_r) begin
            addr_latch_r  <= addr_strap;
            strap_taken_r <= 1'b1;
        end
    end

    assign auto_rpd_enable        = !rpd_disable_r;
    assign scrambler_bypass       = special_r[SP_SCRAMBLER_BYPASS];
    assign enc_bypass             = special_r[SP_ENC_BYPASS];
    assign tx_h_pattern           = special_r[SP_H_PATTERN];
    assign tx_34_pattern          = special_r[SP_34_PATTERN];
    assign force_link_valid       = special_r[SP_FORCE_LINK];
    assign rx_symbol_err_out      = special_r[SP_SYMERR_ENABLE]
                                    && rx_symbol_err_raw;
    assign rx_crs_disable         = special_r[SP_CRS_DISABLE];
    assign dyn_pd_allow           = !special_r[SP_NO_DYN_PD];
    assign neg_loopback           = special_r[SP_NEG_LOOPBACK];
    assign tx_drive_oe_n          = special_r[SP_TX_TRISTATE];
    assign force_polarity_rev     = special_r[SP_FORCE_POLARITY];
    assign autopol_disable        = special_r[SP_AUTOPOL_DISABLE];
    assign squelch_test_disable   = special_r[SP_SQUELCH_DISABLE];
    assign ext_squelch_enable     = special_r[SP_EXT_SQUELCH];
    assign link_integrity_disable = special_r[SP_LINK_INT_DISABLE];
    assign jabber_disable         = special_r[SP_JABBER_DISABLE];

    // ==========================================================
    // Frame and symbol error qualification
    logic       frame_err_seen_r;
    logic [2:0] bad_run_r;
    logic       frame_err_inc;
    logic       symbol_inc;

    // Only the first error of a frame counts
    assign frame_err_inc = rx_frame_active && rx_frame_err
                           && !frame_err_seen_r;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            frame_err_seen_r <= 1'b0;
        end else if (!rx_frame_active) begin
            frame_err_seen_r <= 1'b0;
        end else if (rx_frame_err) begin
            frame_err_seen_r <= 1'b1;
        end
    end

    assign symbol_inc = rx_frame_active && rx_bad_symbol
        && bad_run_r == 3'(SYMBOLS_PER_COUNT - 1);

    // Run resets on a good symbol or at frame end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bad_run_r <= 3'h0;
        end else if (!rx_frame_active || !rx_bad_symbol || symbol_inc) begin
            bad_run_r <= 3'h0;
        end else begin
            bad_run_r <= bad_run_r + 3'h1;
        end
    end

    // ==========================================================
    // Counters
    logic [CNT_WIDTH-1:0] fc_cnt;
    logic [CNT_WIDTH-1:0] dc_cnt;
    logic [CNT_WIDTH-1:0] ef_cnt;
    logic [CNT_WIDTH-1:0] se_cnt;

    sat_clr_counter #(.WIDTH(CNT_WIDTH), .RESET_VAL(CNT_RESET)) u_fc (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .inc     (false_carrier_evt),
        .clr     (rd_take && idx == IDX_FALSE_CARRIER),
        .count_r (fc_cnt)
    );

    sat_clr_counter #(.WIDTH(CNT_WIDTH), .RESET_VAL(CNT_RESET)) u_dc (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .inc     (disconnect_evt),
        .clr     (rd_take && idx == IDX_DISCONNECT),
        .count_r (dc_cnt)
    );

    sat_clr_counter #(.WIDTH(CNT_WIDTH), .RESET_VAL(CNT_RESET)) u_ef (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .inc     (frame_err_inc),
        .clr     (rd_take && idx == IDX_ERROR_FRAME),
        .count_r (ef_cnt)
    );

    sat_clr_counter #(.WIDTH(CNT_WIDTH),
                      .RESET_VAL(SYMERR_CNT_RESET)) u_se (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .inc     (symbol_inc),
        .clr     (rd_take && idx == IDX_SYMBOL_ERROR),
        .count_r (se_cnt)
    );

    // ==========================================================
    // Read data
    logic [15:0] status_word;
    logic [31:0] rd_nxt;
    logic [31:0] rd_r;

    always_comb begin
        status_word = 16'h0000;
        status_word[SC_RPD_DISABLE_BIT] = rpd_disable_r;
        status_word[SC_SYNC_BIT]        = rx_sync;
        status_word[SC_PD100_BIT]       = pd100_state;
        status_word[SC_PD10_BIT]        = pd10_state;
        status_word[SC_POLARITY_BIT]    = rx_polarity_rev;
        status_word[SC_ADDR_LSB +: 5]   = addr_latch_r;
        status_word[SC_SPEED_BIT]       = link_speed100;
        status_word[SC_DUPLEX_BIT]      = link_full_duplex;
    end

    always_comb begin
        case (idx)
            IDX_STATUS_CONTROL:  rd_nxt = {16'h0000, status_word};
            IDX_SPECIAL_CONTROL: rd_nxt = {16'h0000, special_r};
            IDX_ADDRESS_READ:    rd_nxt = {27'h0, addr_latch_r};
            IDX_FALSE_CARRIER:   rd_nxt = {16'h0000, fc_cnt};
            IDX_DISCONNECT:      rd_nxt = {16'h0000, dc_cnt};
            IDX_ERROR_FRAME:     rd_nxt = {16'h0000, ef_cnt};
            IDX_SYMBOL_ERROR:    rd_nxt = {16'h0000, se_cnt};
            default:             rd_nxt = UNMAPPED_READ;
        endcase
    end

    // Data registered with the ack, so the snapshot precedes the clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rd_r <= 32'h0000_0000;
        end else if (rd_take) begin
            rd_r <= rd_nxt;
        end
    end

    assign wb_dat_o = rd_r;

    // ==========================================================
    // Assertions
    sequence s_sym_run;
        (rx_frame_active && rx_bad_symbol) [*6];
    endsequence

    a_ack_one_cycle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wb_cyc_i && wb_stb_i && !ack_r) |=> ack_r ##1 !ack_r)
        else $error("Ack not a single cycle after request");
    a_rpd_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_lo && idx == IDX_STATUS_CONTROL)
        |=> auto_rpd_enable == !$past(wb_dat_i[SC_RPD_DISABLE_BIT]))
        else $error("Reduced power enable does not follow write");
    a_special_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_lo && idx == IDX_SPECIAL_CONTROL)
        |=> scrambler_bypass == $past(wb_dat_i[SP_SCRAMBLER_BYPASS])
            && tx_drive_oe_n == $past(wb_dat_i[SP_TX_TRISTATE]))
        else $error("Special control did not take written value");
    a_symerr_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !special_r[SP_SYMERR_ENABLE] |-> !rx_symbol_err_out)
        else $error("Symbol error output while disabled");
    a_status_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rd_take && idx == IDX_STATUS_CONTROL)
        |=> wb_dat_o[1:0] == $past({link_speed100, link_full_duplex})
            && wb_dat_o[15:14] == 2'b00 && !wb_dat_o[12])
        else $error("Status read mismatch");
    a_clear_on_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rd_take && idx == IDX_FALSE_CARRIER && !false_carrier_evt)
        |=> fc_cnt == 16'h0000)
        else $error("False carrier counter not cleared by read");
    a_disc_saturate: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (dc_cnt == 16'hffff && !(rd_take && idx == IDX_DISCONNECT))
        |=> dc_cnt == 16'hffff)
        else $error("Disconnect counter wrapped");
    a_frame_once: assert property (@(posedge ref_clk) disable iff (!rst_n)
        frame_err_inc ##1 rx_frame_active |-> !frame_err_inc)
        else $error("Error frame counted twice in one frame");
    a_six_symbols: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (bad_run_r == 3'h0 && !symbol_inc) ##0 s_sym_run
        |-> symbol_inc)
        else $error("Six bad symbols did not count once");
endmodule

/* File: include/phy_vsc_pkg.sv */
package phy_vsc_pkg;
    // ==========================================================
    // Register indices; the byte address is four times the index
    localparam logic [7:0]  IDX_STATUS_CONTROL  = 8'h10;
    localparam logic [7:0]  IDX_SPECIAL_CONTROL = 8'h11;
    localparam logic [7:0]  IDX_ADDRESS_READ    = 8'h12;
    localparam logic [7:0]  IDX_FALSE_CARRIER   = 8'h13;
    localparam logic [7:0]  IDX_DISCONNECT      = 8'h14;
    localparam logic [7:0]  IDX_ERROR_FRAME     = 8'h15;
    localparam logic [7:0]  IDX_SYMBOL_ERROR    = 8'h16;
    // ==========================================================
    // Status/control field positions
    localparam int          SC_RPD_DISABLE_BIT  = 13;
    localparam int          SC_SYNC_BIT         = 11;
    localparam int          SC_PD100_BIT        = 10;
    localparam int          SC_PD10_BIT         = 9;
    localparam int          SC_POLARITY_BIT     = 8;
    localparam int          SC_ADDR_LSB         = 2;
    localparam int          SC_SPEED_BIT        = 1;
    localparam int          SC_DUPLEX_BIT       = 0;
    localparam logic        SC_RPD_DISABLE_RST  = 1'b1;
    // ==========================================================
    // Special-control field positions
    localparam int          SP_SCRAMBLER_BYPASS = 15;
    localparam int          SP_ENC_BYPASS       = 14;
    localparam int          SP_H_PATTERN        = 13;
    localparam int          SP_34_PATTERN       = 12;
    localparam int          SP_FORCE_LINK       = 11;
    localparam int          SP_SYMERR_ENABLE    = 10;
    localparam int          SP_CRS_DISABLE      = 9;
    localparam int          SP_NO_DYN_PD        = 8;
    localparam int          SP_NEG_LOOPBACK     = 7;
    localparam int          SP_TX_TRISTATE      = 6;
    localparam int          SP_FORCE_POLARITY   = 5;
    localparam int          SP_AUTOPOL_DISABLE  = 4;
    localparam int          SP_SQUELCH_DISABLE  = 3;
    localparam int          SP_EXT_SQUELCH      = 2;
    localparam int          SP_LINK_INT_DISABLE = 1;
    localparam int          SP_JABBER_DISABLE   = 0;
    localparam logic [15:0] SP_RESET            = 16'h0000;
    // ==========================================================
    // Reset values and counting constants
    localparam logic [4:0]  ADDR_READ_RESET     = 5'h01;
    localparam logic [15:0] CNT_RESET           = 16'h0000;
    localparam logic [15:0] SYMERR_CNT_RESET    = 16'h0001;
    localparam int          SYMBOLS_PER_COUNT   = 6;
    localparam logic [31:0] UNMAPPED_READ       = 32'h0000_0000;
endpackage

/* File: logic/sat_clr_counter.sv */
`timescale 1ns/1ps
module sat_clr_counter
    import phy_vsc_pkg::*;
#(
    parameter int          WIDTH     = 16,
    parameter logic [15:0] RESET_VAL = 16'h0000
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             inc,
    input  wire logic             clr,
    output logic [WIDTH-1:0]      count_r
);
    // Refused at elaboration: the reset value is only 16 bits wide
    if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
        $error("WIDTH must be 1 to 16");
    end

    logic [WIDTH-1:0] count_nxt;
    logic             full;

    assign full = &count_r;

    // An event in the clearing cycle counts as one, so none is lost
    always_comb begin
        count_nxt = count_r;
        if (clr) begin
            count_nxt = inc ? WIDTH'(1) : '0;
        end else if (inc && !full) begin
            count_nxt = count_r + WIDTH'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            count_r <= RESET_VAL[WIDTH-1:0];
        end else begin
            count_r <= count_nxt;
        end
    end

    a_count_holds_full: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (full && !clr) |=> full)
        else $error("Counter left its maximum without a clear");
endmodule

/* File: tb/rx_line_model.sv */
`timescale 1ns/1ps
module rx_line_model (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       start,
    input  wire logic [4:0] n_bad,
    input  wire logic       err_en,
    output logic            rx_frame_active,
    output logic            rx_bad_symbol,
    output logic            rx_frame_err
);
    // ==========================================================
    // Frame timing: twenty symbol cycles, bad symbols lead the frame
    logic [4:0] pos_r;
    logic       idle_r;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rx_frame_active <= 1'b0;
            pos_r           <= 5'h00;
        end else if (start && !rx_frame_active) begin
            rx_frame_active <= 1'b1;
            pos_r           <= 5'h00;
        end else if (rx_frame_active) begin
            pos_r <= pos_r + 5'h01;
            if (pos_r == 5'h13) begin
                rx_frame_active <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Idle line
    // Symbol flag toggles between frames so stray counting shows up
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            idle_r <= 1'b0;
        end else begin
            idle_r <= ~idle_r;
        end
    end

    assign rx_bad_symbol = rx_frame_active ? (pos_r < n_bad) : idle_r;
    assign rx_frame_err  = rx_frame_active && err_en && (pos_r < n_bad);
endmodule

/* File: tb/phy_vendor_status_control_counters_tb.sv */
`timescale 1ns/1ps
module phy_vendor_status_control_counters_tb
    import phy_vsc_pkg::*;
;
    `define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
        errors++; $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); \
    end end
    // ==========================================================
    // Signals
    logic        ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [9:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [4:0]  addr_strap, n_bad, nb;
    logic        rx_sync, pd100_state, pd10_state, rx_polarity_rev;
    logic        link_speed100, link_full_duplex, false_carrier_evt;
    logic        disconnect_evt, rx_frame_active, rx_frame_err, e;
    logic        rx_bad_symbol, rx_symbol_err_raw, frame_start, err_en;
    logic        auto_rpd_enable, scrambler_bypass, enc_bypass;
    logic        tx_h_pattern, tx_34_pattern, force_link_valid;
    logic        rx_symbol_err_out, rx_crs_disable, dyn_pd_allow;
    logic        neg_loopback, tx_drive_oe_n, force_polarity_rev;
    logic        autopol_disable, squelch_test_disable, ext_squelch_enable;
    logic        link_integrity_disable, jabber_disable;
    logic [15:0] rd, wd, ctl_vec;
    int          errors, check_count, seed_v, k, ef, se;

    assign ctl_vec = {scrambler_bypass, enc_bypass, tx_h_pattern,
        tx_34_pattern, force_link_valid, rx_symbol_err_out, rx_crs_disable,
        ~dyn_pd_allow, neg_loopback, tx_drive_oe_n, force_polarity_rev,
        autopol_disable, squelch_test_disable, ext_squelch_enable,
        link_integrity_disable, jabber_disable};

    phy_vendor_regs DUT (
        .ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .addr_strap, .rx_sync,
        .pd100_state, .pd10_state, .rx_polarity_rev, .link_speed100,
        .link_full_duplex, .false_carrier_evt, .disconnect_evt,
        .rx_frame_active, .rx_frame_err, .rx_bad_symbol, .rx_symbol_err_raw,
        .auto_rpd_enable, .scrambler_bypass, .enc_bypass, .tx_h_pattern,
        .tx_34_pattern, .force_link_valid, .rx_symbol_err_out,
        .rx_crs_disable, .dyn_pd_allow, .neg_loopback, .tx_drive_oe_n,
        .force_polarity_rev, .autopol_disable, .squelch_test_disable,
        .ext_squelch_enable, .link_integrity_disable, .jabber_disable);

    rx_line_model line_model (
        .ref_clk, .rst_n, .start(frame_start), .n_bad, .err_en,
        .rx_frame_active, .rx_bad_symbol, .rx_frame_err);

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // ==========================================================
    // Tasks and expectations
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Classic cycle; ack is read at the edge, before that edge's updates
    task automatic wb(input logic we, input logic [7:0] idx,
                      input logic [15:0] d, input logic [3:0] sel);
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= sel;
        wb_dat_i <= {16'h0000, d};
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge ref_clk);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o[15:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [15:0] x);
        wb(1'b0, idx, 16'h0000, 4'hf);
        `CHK(rd, x)
        `CHK(wb_dat_o[31:16], 16'h0000)
    endtask

    task automatic pulse(input int which, input int cnt);
        repeat (cnt) begin
            @(posedge ref_clk);
            if (which == 0) false_carrier_evt <= 1'b1;
            else disconnect_evt <= 1'b1;
            @(posedge ref_clk);
            false_carrier_evt <= 1'b0;
            disconnect_evt    <= 1'b0;
        end
    endtask

    task automatic frame(input logic [4:0] b, input logic er);
        @(posedge ref_clk);
        n_bad       <= b;
        err_en      <= er;
        frame_start <= 1'b1;
        @(posedge ref_clk);
        frame_start <= 1'b0;
        repeat (24) @(posedge ref_clk);
    endtask

    function automatic logic [15:0] st_exp(input logic rpd);
        return {2'b00, rpd, 1'b0, rx_sync, pd100_state, pd10_state,
                rx_polarity_rev, 1'b0, addr_strap, link_speed100,
                link_full_duplex};
    endfunction

    // ==========================================================
    // Tests
    initial begin
        errors = 0;
        check_count = 0;
        seed_v = $urandom(32'h04ffa251);
        {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} = '0;
        {wb_dat_i, rx_sync, rx_polarity_rev, link_speed100} = '0;
        {link_full_duplex, false_carrier_evt, disconnect_evt} = '0;
        {rx_symbol_err_raw, frame_start, err_en, n_bad} = '0;
        {pd100_state, pd10_state} = 2'b11;
        addr_strap = 5'($urandom);
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        rdc(IDX_SPECIAL_CONTROL, SP_RESET);
        `CHK(auto_rpd_enable, 1'b0)
        rdc(IDX_STATUS_CONTROL, st_exp(1'b1));
        rdc(IDX_ADDRESS_READ, {11'h000, addr_strap});
        rdc(IDX_SYMBOL_ERROR, SYMERR_CNT_RESET);
        rdc(IDX_FALSE_CARRIER, CNT_RESET);
        rdc(IDX_DISCONNECT, CNT_RESET);
        rdc(IDX_ERROR_FRAME, CNT_RESET);
        $display("test reset values done");
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            {rx_sync, pd100_state, pd10_state, rx_polarity_rev,
             link_speed100, link_full_duplex} <= 6'($urandom);
            wd = 16'($urandom) & 16'h2fff;
            wb(1'b1, IDX_STATUS_CONTROL, wd, 4'hf);
            rdc(IDX_STATUS_CONTROL, st_exp(wd[13]));
            `CHK(auto_rpd_enable, ~wd[13])
        end
        $display("test status done");
        rx_symbol_err_raw <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            wd = (i == 0) ? 16'hffff : 16'($urandom);
            wb(1'b1, IDX_SPECIAL_CONTROL, wd, 4'hf);
            `CHK(ctl_vec, wd)
            `CHK(ctl_vec[1:0], wd[1:0])
            rdc(IDX_SPECIAL_CONTROL, wd);
        end
        wb(1'b1, IDX_SPECIAL_CONTROL, ~wd, 4'b1101);
        rdc(IDX_SPECIAL_CONTROL, wd);
        @(posedge ref_clk);
        rx_symbol_err_raw <= 1'b0;
        @(posedge ref_clk);
        `CHK(rx_symbol_err_out, 1'b0)
        wb(1'b1, IDX_ADDRESS_READ, 16'hffff, 4'hf);
        rdc(IDX_ADDRESS_READ, {11'h000, addr_strap});
        rdc(8'h20, 16'h0000);
        $display("test special control done");
        for (int w = 0; w < 2; w++) begin
            k = 1 + $urandom % 12;
            pulse(w, k);
            rdc(w ? IDX_DISCONNECT : IDX_FALSE_CARRIER, 16'(k));
            rdc(w ? IDX_DISCONNECT : IDX_FALSE_CARRIER, 16'h0);
        end
        $display("test event counters done");
        ef = 0;
        se = 0;
        for (int i = 0; i < 8; i++) begin
            nb = (i == 0) ? 5'd5 : (i == 1) ? 5'd6 : (i == 2) ? 5'd18
                 : 5'($urandom % 20);
            e = (i < 3) ? 1'b1 : 1'($urandom);
            frame(nb, e);
            ef += (e && nb != 5'd0) ? 1 : 0;
            se += int'(nb) / SYMBOLS_PER_COUNT;
        end
        rdc(IDX_ERROR_FRAME, 16'(ef));
        rdc(IDX_SYMBOL_ERROR, 16'(se));
        $display("test frame counters done");
        @(posedge ref_clk);
        disconnect_evt <= 1'b1;
        repeat (65540) @(posedge ref_clk);
        disconnect_evt <= 1'b0;
        rdc(IDX_DISCONNECT, 16'hffff);
        rdc(IDX_DISCONNECT, 16'h0000);
        $display("test saturation done");
        test_done;
    end

    // Run needs about 66000 cycles; a hang ends well before 100000
    initial begin
        repeat (80000) @(posedge ref_clk);
        errors++;
        test_done;
    end
endmodule
